// *** src/sync_slave_pkg.sv ***
// Constants for the synchronous slave serial port
package sync_slave_pkg;
  // Register byte addresses on APB
  localparam logic [7:0] ADDR_INTERRUPT_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_IRQ_FLAGS         = 8'h04;
  localparam logic [7:0] ADDR_IRQ_ENABLES       = 8'h08;
  localparam logic [7:0] ADDR_IRQ_PRIORITY      = 8'h0c;
  localparam logic [7:0] ADDR_RECEIVE_STATUS    = 8'h10;
  localparam logic [7:0] ADDR_PORT_C_DIRECTION  = 8'h14;
  localparam logic [7:0] ADDR_TRANSMIT_HOLDING  = 8'h18;
  localparam logic [7:0] ADDR_TRANSMIT_STATUS   = 8'h1c;
  localparam logic [7:0] ADDR_BAUD_CONTROL      = 8'h20;
  localparam logic [7:0] ADDR_BAUD_DIV_HIGH     = 8'h24;
  localparam logic [7:0] ADDR_BAUD_DIV_LOW      = 8'h28;
  localparam logic [7:0] ADDR_RECEIVE_FIFO      = 8'h2c;
  localparam logic [7:0] ADDR_SLEEP_CONTROL     = 8'h30;
  // interrupt_control fields
  localparam int BIT_GLOBAL_IRQ_ENABLE     = 7;
  localparam int BIT_PERIPHERAL_IRQ_ENABLE = 6;
  // Flag / enable / priority fields
  localparam int BIT_RECEIVE_IRQ  = 5;
  localparam int BIT_TRANSMIT_IRQ = 4;
  // receive_status_control fields
  localparam int BIT_PORT_ENABLE        = 7;
  localparam int BIT_RX_NINE_SELECT     = 6;
  localparam int BIT_SINGLE_RX_ENABLE   = 5;
  localparam int BIT_CONTINUOUS_RX      = 4;
  localparam int BIT_OVERRUN_ERROR      = 1;
  localparam int BIT_RECEIVED_NINTH     = 0;
  // transmit_status_control fields
  localparam int BIT_CLOCK_ORIGIN       = 7;
  localparam int BIT_TX_NINE_SELECT     = 6;
  localparam int BIT_TRANSMIT_ENABLE    = 5;
  localparam int BIT_SYNC_MODE          = 4;
  localparam int BIT_SHIFTER_EMPTY      = 1;
  localparam int BIT_TRANSMIT_NINTH     = 0;
  // Writable masks; unimplemented bits read zero
  localparam logic [7:0] MASK_IRQ_FLAGS_ENABLES = 8'h7f;
  localparam logic [7:0] MASK_RECEIVE_STATUS_WR = 8'hf0;
  localparam logic [7:0] MASK_TRANSMIT_STATUS   = 8'hf1;
  localparam logic [7:0] MASK_BAUD_CONTROL      = 8'h3b;
  // Reset values
  localparam logic [7:0] RESET_ZERO             = 8'h00;
  localparam logic [7:0] RESET_DIRECTION        = 8'hff;
  // Receive FIFO depth and character width
  localparam int FIFO_DEPTH = 2;
  localparam int CHAR_BITS  = 9;
endpackage

// *** src/serial_slave_shifter.sv ***
// Link-side shifter: sampled clock edges drive transmit and receive shifts
`timescale 1ns/1ps
module serial_slave_shifter
  import sync_slave_pkg::*;
#(
  parameter int WIDTH = CHAR_BITS
) (
  // Clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             clear,
  // Sampled link pins
  input  wire logic             clk_rise,
  input  wire logic             clk_fall,
  input  wire logic             data_in,
  // Configuration
  input  wire logic             rx_mode,
  input  wire logic             nine_bit,
  // Transmit side
  input  wire logic             tx_load,
  input  wire logic [WIDTH-1:0] tx_char,
  output logic                  tx_busy,
  output logic                  tx_done,
  output logic                  data_out,
  // Receive side
  input  wire logic             rx_block,
  output logic                  rx_done,
  output logic      [WIDTH-1:0] rx_char
);
  logic [WIDTH-1:0] shift_reg;
  logic [3:0]       count_reg;
  logic             busy_reg;
  logic             started_reg;
  logic [3:0]       char_len;
  logic             last_bit;

  // Nine or eight bits per character
  assign char_len = nine_bit ? 4'd9 : 4'd8;
  assign last_bit = (count_reg == char_len - 4'd1);
  assign tx_busy  = busy_reg;

  // Leading edge drives a bit, trailing edge counts it, LSB first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_reg   <= '0;
      count_reg   <= '0;
      busy_reg    <= 1'b0;
      started_reg <= 1'b0;
      data_out    <= 1'b0;
      tx_done     <= 1'b0;
      rx_done     <= 1'b0;
      rx_char     <= '0;
    end else begin
      tx_done <= 1'b0;
      rx_done <= 1'b0;
      if (clear) begin
        busy_reg    <= 1'b0;
        started_reg <= 1'b0;
        count_reg   <= '0;
      end else if (rx_mode) begin
        busy_reg <= 1'b0;
        if (clk_fall && !rx_block) begin
          shift_reg <= {1'b0, shift_reg[WIDTH-1:1]};
          shift_reg[WIDTH-1] <= data_in;
          if (last_bit) begin
            count_reg <= '0;
            rx_done   <= 1'b1;
            rx_char   <= nine_bit ? {data_in, shift_reg[WIDTH-1:1]}
                                  : {1'b0, data_in, shift_reg[WIDTH-1:2]};
          end else begin
            count_reg <= count_reg + 4'd1;
          end
        end
      end else if (tx_load && !busy_reg) begin
        shift_reg   <= tx_char;
        busy_reg    <= 1'b1;
        started_reg <= 1'b0;
        count_reg   <= '0;
      end else if (busy_reg) begin
        if (clk_rise) begin
          data_out    <= shift_reg[0];
          shift_reg   <= {1'b0, shift_reg[WIDTH-1:1]};
          started_reg <= 1'b1;
        end else if (clk_fall && started_reg) begin
          started_reg <= 1'b0;
          if (last_bit) begin
            busy_reg  <= 1'b0;
            tx_done   <= 1'b1;
            count_reg <= '0;
          end else begin
            count_reg <= count_reg + 4'd1;
          end
        end
      end
    end
  end
endmodule

// *** src/sync_slave_serial_port.sv ***
// Synchronous slave serial port with APB register file
//
// Local design decisions: register access over APB and the register offsets.
`timescale 1ns/1ps
module sync_slave_serial_port
  import sync_slave_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  // APB slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Serial link pins
  input  wire logic        serial_clock_pin_in,
  input  wire logic        serial_data_pin_in,
  output logic             serial_data_pin_out,
  output logic             serial_data_pin_oe,
  output logic             serial_clock_pin_oe,
  // Core wake and interrupt request
  output logic             wake_request,
  output logic             irq_vector
);
  // Registers
  logic [7:0]           interrupt_control_reg;
  logic [7:0]           flags_en_reg;
  logic [7:0]           priority_reg;
  logic [7:0]           rx_ctrl_reg;
  logic [7:0]           direction_reg;
  logic [7:0]           tx_ctrl_reg;
  logic [7:0]           baud_ctrl_reg;
  logic [7:0]           div_high_reg;
  logic [7:0]           div_low_reg;
  logic                 sleep_reg;
  logic [7:0]           hold_reg;
  logic                 hold_ninth_reg;
  logic                 hold_full_reg;
  logic                 overrun_reg;
  logic [CHAR_BITS-1:0] fifo_mem [DEPTH];
  logic [1:0]           fifo_count_reg;
  logic                 rd_ptr_reg;
  logic                 wr_ptr_reg;
  // Two-stage synchronisers and edge history
  logic [1:0]           clk_sync_reg;
  logic [1:0]           dat_sync_reg;
  logic                 clk_prev_reg;

  // APB decode
  logic access;
  logic wr_en;
  logic rd_en;
  logic addr_known;
  logic sel_int;
  logic sel_flg;
  logic sel_ien;
  logic sel_pri;
  logic sel_rcs;
  logic sel_dir;
  logic sel_txh;
  logic sel_txs;
  logic sel_bdc;
  logic sel_bdh;
  logic sel_bdl;
  logic sel_rxf;
  logic sel_slp;
  assign access  = psel && penable;
  assign wr_en   = access && pwrite;
  assign rd_en   = access && !pwrite;
  assign sel_int = (paddr == ADDR_INTERRUPT_CONTROL);
  assign sel_flg = (paddr == ADDR_IRQ_FLAGS);
  assign sel_ien = (paddr == ADDR_IRQ_ENABLES);
  assign sel_pri = (paddr == ADDR_IRQ_PRIORITY);
  assign sel_rcs = (paddr == ADDR_RECEIVE_STATUS);
  assign sel_dir = (paddr == ADDR_PORT_C_DIRECTION);
  assign sel_txh = (paddr == ADDR_TRANSMIT_HOLDING);
  assign sel_txs = (paddr == ADDR_TRANSMIT_STATUS);
  assign sel_bdc = (paddr == ADDR_BAUD_CONTROL);
  assign sel_bdh = (paddr == ADDR_BAUD_DIV_HIGH);
  assign sel_bdl = (paddr == ADDR_BAUD_DIV_LOW);
  assign sel_rxf = (paddr == ADDR_RECEIVE_FIFO);
  assign sel_slp = (paddr == ADDR_SLEEP_CONTROL);
  assign addr_known = sel_int | sel_flg | sel_ien | sel_pri | sel_rcs | sel_dir
                    | sel_txh | sel_txs | sel_bdc | sel_bdh | sel_bdl | sel_rxf
                    | sel_slp;
  // Every access completes in its access cycle; no wait states added
  // Zero-wait slave; unmapped addresses answer with an error
  assign pready  = 1'b1;
  assign pslverr = access && !addr_known;

  // Mode decode
  // Slave only with port, sync and external clock all selected
  logic port_on;
  logic sync_on;
  logic slave_on;
  logic rx_mode;
  logic rx_nine;
  logic tx_nine;
  logic tx_en;
  logic cont_rx;
  assign port_on  = rx_ctrl_reg[BIT_PORT_ENABLE];
  assign sync_on  = tx_ctrl_reg[BIT_SYNC_MODE];
  assign slave_on = port_on && sync_on && !tx_ctrl_reg[BIT_CLOCK_ORIGIN];
  assign cont_rx  = rx_ctrl_reg[BIT_CONTINUOUS_RX];
  // Either enable selects receive; in slave only continuous does work
  assign rx_mode  = cont_rx || rx_ctrl_reg[BIT_SINGLE_RX_ENABLE];
  assign rx_nine  = rx_ctrl_reg[BIT_RX_NINE_SELECT];
  assign tx_nine  = tx_ctrl_reg[BIT_TX_NINE_SELECT];
  assign tx_en    = tx_ctrl_reg[BIT_TRANSMIT_ENABLE];

  // Link edges are seen two to three clocks late; data is delayed alike,
  // so a falling-edge sample still sees the bit it belongs to
  // Pin synchronisers; only the second stage is read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_sync_reg <= 2'b00;
      dat_sync_reg <= 2'b00;
      clk_prev_reg <= 1'b0;
    end else begin
      clk_sync_reg <= {clk_sync_reg[0], serial_clock_pin_in};
      dat_sync_reg <= {dat_sync_reg[0], serial_data_pin_in};
      clk_prev_reg <= clk_sync_reg[1];
    end
  end

  logic clk_rise;
  logic clk_fall;
  assign clk_rise = clk_sync_reg[1] && !clk_prev_reg;
  assign clk_fall = !clk_sync_reg[1] && clk_prev_reg;

  // Shifter hookup
  logic                 shift_clear;
  logic                 tx_busy;
  logic                 rx_done;
  logic                 tx_load;
  logic                 rx_active;
  logic                 fifo_full;
  logic                 fifo_empty;
  logic                 rx_block;
  logic [CHAR_BITS-1:0] rx_char;
  logic [CHAR_BITS-1:0] tx_char;
  // Done pulse unused: the holding flag already drives the reload
  assign shift_clear = !slave_on;
  assign rx_active   = slave_on && cont_rx;
  assign fifo_full   = (fifo_count_reg == 2'(DEPTH));
  assign fifo_empty  = (fifo_count_reg == 2'd0);
  // Stop taking bits while overrun stands
  assign rx_block    = overrun_reg || !rx_active;
  // Holding register feeds the shifter as soon as it is idle
  assign tx_load     = slave_on && !rx_mode && tx_en && hold_full_reg;
  assign tx_char     = {tx_nine ? hold_ninth_reg : 1'b0, hold_reg};

  serial_slave_shifter #(
    .WIDTH(CHAR_BITS)
  ) u_shifter (
    .pclk     (pclk),
    .presetn  (presetn),
    .clear    (shift_clear),
    .clk_rise (clk_rise),
    .clk_fall (clk_fall),
    .data_in  (dat_sync_reg[1]),
    .rx_mode  (rx_mode),
    .nine_bit (rx_mode ? rx_nine : tx_nine),
    .tx_load  (tx_load),
    .tx_char  (tx_char),
    .tx_busy  (tx_busy),
    .tx_done  (),
    .data_out (serial_data_pin_out),
    .rx_block (rx_block),
    .rx_done  (rx_done),
    .rx_char  (rx_char)
  );

  // Data pin released between characters so the master may drive it
  // Pin drivers: clock never driven in slave, data only when transmitting
  assign serial_clock_pin_oe = 1'b0;
  assign serial_data_pin_oe  = slave_on && !rx_mode && tx_en && tx_busy;

  // FIFO push and pop
  logic push;
  logic pop;
  logic take_hold;
  assign push      = rx_done && rx_active && !fifo_full;
  assign pop       = rd_en && sel_rxf && !fifo_empty;
  assign take_hold = tx_load && !tx_busy;

  // Flags are live state, not software-cleared bits
  logic tx_flag;
  logic rx_flag;
  logic top_ninth;
  assign tx_flag   = tx_en && !hold_full_reg;
  assign rx_flag   = !fifo_empty;
  assign top_ninth = rx_nine ? fifo_mem[rd_ptr_reg][CHAR_BITS-1] : 1'b0;

  // Priority bits are kept for software only; one request line leaves
  // Divisor and baud bits are kept for the map; slave uses no divisor
  // Register file write side
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      interrupt_control_reg    <= RESET_ZERO;
      flags_en_reg  <= RESET_ZERO;
      priority_reg  <= RESET_ZERO;
      rx_ctrl_reg   <= RESET_ZERO;
      direction_reg <= RESET_DIRECTION;
      tx_ctrl_reg   <= RESET_ZERO;
      baud_ctrl_reg <= RESET_ZERO;
      div_high_reg  <= RESET_ZERO;
      div_low_reg   <= RESET_ZERO;
      sleep_reg     <= 1'b0;
    end else if (wr_en) begin
      if (sel_int) interrupt_control_reg <= pwdata[7:0];
      if (sel_ien) flags_en_reg <= pwdata[7:0] & MASK_IRQ_FLAGS_ENABLES;
      if (sel_pri) priority_reg <= pwdata[7:0] & MASK_IRQ_FLAGS_ENABLES;
      if (sel_rcs) rx_ctrl_reg <= pwdata[7:0] & MASK_RECEIVE_STATUS_WR;
      if (sel_dir) direction_reg <= pwdata[7:0];
      if (sel_txs) tx_ctrl_reg <= pwdata[7:0] & MASK_TRANSMIT_STATUS;
      if (sel_bdc) baud_ctrl_reg <= pwdata[7:0] & MASK_BAUD_CONTROL;
      if (sel_bdh) div_high_reg <= pwdata[7:0];
      if (sel_bdl) div_low_reg <= pwdata[7:0];
      if (sel_slp) sleep_reg <= pwdata[0];
    end
  end

  // A write while the shifter runs waits here, which keeps the flag low
  // Holding register: write fills it, shifter load empties it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_reg       <= RESET_ZERO;
      hold_ninth_reg <= 1'b0;
      hold_full_reg  <= 1'b0;
    end else if (!slave_on || !tx_en) begin
      hold_full_reg  <= 1'b0;
    end else if (wr_en && sel_txh) begin
      hold_reg       <= pwdata[7:0];
      hold_ninth_reg <= tx_ctrl_reg[BIT_TRANSMIT_NINTH];
      hold_full_reg  <= 1'b1;
    end else if (take_hold) begin
      hold_full_reg  <= 1'b0;
    end
  end

  // Overrun freezes the stored entries; software may still read both
  // Clearing continuous receive drops overrun but keeps the entries
  // Receive FIFO and overrun
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fifo_count_reg <= 2'd0;
      rd_ptr_reg     <= 1'b0;
      wr_ptr_reg     <= 1'b0;
      overrun_reg    <= 1'b0;
    end else if (!port_on || !cont_rx) begin
      overrun_reg    <= 1'b0;
      if (!port_on) begin
        fifo_count_reg <= 2'd0;
        rd_ptr_reg     <= 1'b0;
        wr_ptr_reg     <= 1'b0;
      end else if (pop) begin
        fifo_count_reg <= fifo_count_reg - 2'd1;
        rd_ptr_reg     <= !rd_ptr_reg;
      end
    end else begin
      if (push) begin
        wr_ptr_reg <= !wr_ptr_reg;
      end
      if (pop) begin
        rd_ptr_reg <= !rd_ptr_reg;
      end
      fifo_count_reg <= fifo_count_reg + {1'b0, push} - {1'b0, pop};
      // Third full character with FIFO full; stored ones kept
      if (rx_done && rx_active && fifo_full) begin
        overrun_reg <= 1'b1;
      end
    end
  end

  // FIFO storage, one loop over entries
  for (genvar i = 0; i < DEPTH; i++) begin : g_fifo
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        fifo_mem[i] <= '0;
      end else if (push && (wr_ptr_reg == 1'(i))) begin
        fifo_mem[i] <= rx_char;
      end
    end
  end

  // Wake and vector requests
  // Levels, not pulses: a request stands while an enabled flag stands
  logic tx_irq;
  logic rx_irq;
  logic periph_irq;
  assign tx_irq       = tx_flag && flags_en_reg[BIT_TRANSMIT_IRQ];
  assign rx_irq       = rx_flag && flags_en_reg[BIT_RECEIVE_IRQ];
  assign periph_irq   = interrupt_control_reg[BIT_PERIPHERAL_IRQ_ENABLE] && (tx_irq || rx_irq);
  assign wake_request = sleep_reg && periph_irq;
  assign irq_vector   = periph_irq && interrupt_control_reg[BIT_GLOBAL_IRQ_ENABLE];

  // Read multiplexer; status bits live, reserved bits zero
  // An empty FIFO read returns the stale entry and pops nothing
  logic [7:0] flags_rd;
  logic [7:0] rcs_rd;
  logic [7:0] txs_rd;
  logic [7:0] rd_byte;
  assign flags_rd = {2'b00, rx_flag, tx_flag, 4'h0};
  assign rcs_rd   = {rx_ctrl_reg[7:4], 2'b00, overrun_reg, top_ninth};
  assign txs_rd   = {tx_ctrl_reg[7:2], !tx_busy && !hold_full_reg,
                     tx_ctrl_reg[BIT_TRANSMIT_NINTH]};
  assign rd_byte  = sel_int ? interrupt_control_reg
                  : sel_flg ? flags_rd
                  : sel_ien ? flags_en_reg
                  : sel_pri ? priority_reg
                  : sel_rcs ? rcs_rd
                  : sel_dir ? direction_reg
                  : sel_txs ? txs_rd
                  : sel_bdc ? baud_ctrl_reg
                  : sel_bdh ? div_high_reg
                  : sel_bdl ? div_low_reg
                  : sel_rxf ? fifo_mem[rd_ptr_reg][7:0]
                  : sel_slp ? {7'h00, sleep_reg}
                  : 8'h00;
  assign prdata   = {24'h000000, rd_byte};
endmodule

// *** verif/sync_slave_props.sv ***
// Port-level checker for the synchronous slave serial port
`timescale 1ns/1ps
module sync_slave_props
  import sync_slave_pkg::*;
(
  // APB slave
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Serial link pins
  input wire logic        serial_clock_pin_in,
  input wire logic        serial_data_pin_in,
  input wire logic        serial_data_pin_out,
  input wire logic        serial_data_pin_oe,
  input wire logic        serial_clock_pin_oe,
  // Core wake and interrupt request
  input wire logic        wake_request,
  input wire logic        irq_vector
);
  logic [7:0] ictl_reg;
  logic [7:0] rcs_reg;
  logic       sleep_reg;
  // Decode of a taken access and of the mapped window
  wire        access = psel && penable;
  wire        mapped = (paddr[1:0] == 2'b00) && (paddr <= ADDR_SLEEP_CONTROL);
  wire        wr_now = access && pwrite;
  // Shadow copies of the gating bits, so gated outputs can be judged from the bus alone
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ictl_reg  <= 8'h00;
      rcs_reg   <= 8'h00;
      sleep_reg <= 1'b0;
    end else if (wr_now) begin
      if (paddr == ADDR_INTERRUPT_CONTROL) ictl_reg <= pwdata[7:0];
      if (paddr == ADDR_RECEIVE_STATUS) rcs_reg <= pwdata[7:0];
      if (paddr == ADDR_SLEEP_CONTROL) sleep_reg <= pwdata[0];
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_zero_wait: assert property (access |-> pready)
    else $error("pready low in access phase");
  a_slverr_unmapped: assert property (access && !mapped |-> pslverr)
    else $error("unmapped access not refused");
  a_slverr_mapped: assert property (access && mapped |-> !pslverr)
    else $error("mapped access refused");
  a_read_upper_zero: assert property (access && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_unmapped_read_zero: assert property (access && !pwrite && !mapped |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  a_clock_pin_idle: assert property (!serial_clock_pin_oe)
    else $error("clock pin driven in slave mode");
  a_wake_gated: assert property (wake_request |-> sleep_reg && ictl_reg[BIT_PERIPHERAL_IRQ_ENABLE])
    else $error("wake without sleep and peripheral enable");
  a_vector_gated: assert property (irq_vector |-> ictl_reg[7] && ictl_reg[6])
    else $error("vector without global and peripheral enable");
  a_drive_transmit_only: assert property (serial_data_pin_oe |-> rcs_reg[7:4] ==? 4'b1?00)
    else $error("data pin driven outside transmit mode");
  // Main scenarios reached
  c_wake: cover property (wake_request);
  c_vector: cover property (irq_vector);
  c_drive: cover property (serial_data_pin_oe);
  c_refuse: cover property (access && pslverr);
endmodule

bind sync_slave_serial_port sync_slave_props u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .serial_clock_pin_in(serial_clock_pin_in), .serial_data_pin_in(serial_data_pin_in),
  .serial_data_pin_out(serial_data_pin_out), .serial_data_pin_oe(serial_data_pin_oe),
  .serial_clock_pin_oe(serial_clock_pin_oe), .wake_request(wake_request),
  .irq_vector(irq_vector)
);

// *** verif/link_master_model.sv ***
// Behavioural external master that clocks the serial link
`timescale 1ns/1ps
module link_master_model (
  // Link pins
  output logic      sck,
  output logic      sdo,
  input  wire logic sdi
);
  initial begin
    sck = 1'b0;
    sdo = 1'b0;
  end
  // One frame of n clocks; the clock idles low between frames
  task automatic xfer(input int n, input logic [8:0] tx, output logic [8:0] rx);
    rx = 9'h0;
    for (int i = 0; i < n; i++) begin
      sdo <= tx[i];
      #100;
      sck <= 1'b1;
      #200;
      sck <= 1'b0;
      rx[i] = sdi;
      #100;
    end
    // Released line must not look like held data; gap before next frame
    sdo <= ~sdo;
    #100;
  endtask
endmodule

// *** verif/tb.sv ***
// Self-checking bench for the synchronous slave serial port
`timescale 1ns/1ps
module tb;
  import sync_slave_pkg::*;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  wire  [31:0] prdata;
  wire         pready;
  wire         pslverr;
  wire         sck;
  wire         m_sdo;
  wire         data_wire;
  wire         d_out;
  wire         d_oe;
  wire         wake_request;
  wire         irq_vector;
  int          num_errors;
  int          n_compared;
  int          cycles = 0;
  logic [31:0] rd;
  logic        err;
  logic [8:0]  got;
  // The data wire carries whichever party drives it
  assign data_wire = d_oe ? d_out : m_sdo;
  sync_slave_serial_port dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .serial_clock_pin_in(sck), .serial_data_pin_in(data_wire), .serial_data_pin_out(d_out),
    .serial_data_pin_oe(d_oe), .serial_clock_pin_oe(), .wake_request(wake_request),
    .irq_vector(irq_vector));
  // Link pins are digital only here; no analog function shares them
  link_master_model link (.sck(sck), .sdo(m_sdo), .sdi(data_wire));
  initial pclk = 1'b0;
  always #25 pclk = ~pclk;
  // Hang guard, well above the several hundred cycles the run needs
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      num_errors++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // One APB transfer; result left in rd and err
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int   n;
    logic ok;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    // Answer read while settled, before the edge that completes the access
    do begin
      @(negedge pclk);
      ok  = pready;
      rd  = prdata;
      err = pslverr;
      @(posedge pclk);
      n++;
    end while (ok !== 1'b1 && n < 16);
    if (n >= 16) num_errors++;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, {24'h0, exp});
  endtask
  // Poll a register until all bits of m are set, bounded
  task automatic poll(input logic [7:0] a, input logic [7:0] m);
    apb(1'b0, a, 32'h0);
    for (int i = 0; i < 40 && (rd[7:0] & m) != m; i++) apb(1'b0, a, 32'h0);
  endtask
  task automatic t_reset_map();
    rdc(ADDR_PORT_C_DIRECTION, RESET_DIRECTION);
    rdc(ADDR_RECEIVE_STATUS, RESET_ZERO);
    rdc(ADDR_INTERRUPT_CONTROL, RESET_ZERO);
    wr(ADDR_IRQ_ENABLES, 32'hff);
    rdc(ADDR_IRQ_ENABLES, MASK_IRQ_FLAGS_ENABLES);
    wr(ADDR_RECEIVE_STATUS, 32'h0f);
    rdc(ADDR_RECEIVE_STATUS, 8'h00);
    rdc(ADDR_TRANSMIT_HOLDING, 8'h00);
    apb(1'b0, 8'h34, 32'h0);
    chk(err, 1'b1);
    chk(rd, 32'h0);
    wr(ADDR_IRQ_ENABLES, 32'h0);
    wr(ADDR_PORT_C_DIRECTION, 32'hff);
  endtask
  // Two characters queued in sleep, nine-bit, ninth bit set
  task automatic t_transmit();
    wr(ADDR_INTERRUPT_CONTROL, 32'h40);
    wr(ADDR_IRQ_ENABLES, 32'h10);
    wr(ADDR_RECEIVE_STATUS, 32'h80);
    wr(ADDR_TRANSMIT_STATUS, 32'h50);
    wr(ADDR_TRANSMIT_STATUS, 32'h70);
    wr(ADDR_TRANSMIT_STATUS, 32'h71);
    wr(ADDR_SLEEP_CONTROL, 32'h1);
    wr(ADDR_TRANSMIT_HOLDING, 32'ha5);
    wr(ADDR_TRANSMIT_HOLDING, 32'h3c);
    rdc(ADDR_IRQ_FLAGS, 8'h00);
    chk(wake_request, 1'b0);
    link.xfer(9, 9'h0, got);
    chk(got, 9'h1a5);
    poll(ADDR_IRQ_FLAGS, 8'h10);
    chk(rd, 32'h10);
    chk(wake_request, 1'b1);
    chk(irq_vector, 1'b0);
    wr(ADDR_INTERRUPT_CONTROL, 32'hc0);
    repeat (3) @(posedge pclk);
    chk(irq_vector, 1'b1);
    link.xfer(9, 9'h0, got);
    chk(got, 9'h13c);
    wr(ADDR_INTERRUPT_CONTROL, 32'h0);
    wr(ADDR_SLEEP_CONTROL, 32'h0);
    wr(ADDR_TRANSMIT_STATUS, 32'h10);
  endtask
  // Disabled port ignores a frame, then FIFO fill, overrun and recovery
  task automatic t_receive();
    wr(ADDR_RECEIVE_STATUS, 32'h10);
    link.xfer(8, 9'h055, got);
    rdc(ADDR_IRQ_FLAGS, 8'h00);
    wr(ADDR_IRQ_ENABLES, 32'h20);
    wr(ADDR_INTERRUPT_CONTROL, 32'h40);
    wr(ADDR_SLEEP_CONTROL, 32'h1);
    wr(ADDR_RECEIVE_STATUS, 32'h90);
    chk(wake_request, 1'b0);
    link.xfer(8, 9'h0c3, got);
    poll(ADDR_IRQ_FLAGS, 8'h20);
    chk(rd, 32'h20);
    chk(wake_request, 1'b1);
    link.xfer(8, 9'h05a, got);
    link.xfer(8, 9'h0f0, got);
    poll(ADDR_RECEIVE_STATUS, 8'h02);
    chk(rd, 32'h92);
    rdc(ADDR_RECEIVE_FIFO, 8'hc3);
    rdc(ADDR_RECEIVE_FIFO, 8'h5a);
    rdc(ADDR_IRQ_FLAGS, 8'h00);
    wr(ADDR_RECEIVE_STATUS, 32'h80);
    rdc(ADDR_RECEIVE_STATUS, 8'h80);
    wr(ADDR_RECEIVE_STATUS, 32'hf0);
    link.xfer(9, 9'h1a6, got);
    poll(ADDR_IRQ_FLAGS, 8'h20);
    rdc(ADDR_RECEIVE_STATUS, 8'hf1);
    rdc(ADDR_RECEIVE_FIFO, 8'ha6);
    wr(ADDR_RECEIVE_STATUS, 32'h0);
    wr(ADDR_SLEEP_CONTROL, 32'h0);
  endtask
  initial begin
    presetn    = 1'b0;
    psel       = 1'b0;
    penable    = 1'b0;
    pwrite     = 1'b0;
    paddr      = 8'h00;
    pwdata     = 32'h0;
    num_errors = 0;
    n_compared = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_reset_map();
    t_transmit();
    t_receive();
    tally_and_finish();
  end
endmodule
